// *** synth_seq_cfg.svh ***
/*
  Constants of the frame and slot sequencer: timing counts, memory layout,
  datapath widths and power-up values. Assumes a 40 MHz sequencer clock.
*/
`ifndef SYNTH_SEQ_CFG_SVH
`define SYNTH_SEQ_CFG_SVH

// ---------------------------------------------------------------------------
// clock and slot timing
// ---------------------------------------------------------------------------
`define CLK_NS          25
`define SLOT_CYCLES     68
`define SLOT_LAST       7'(`SLOT_CYCLES - 1)
`define MIX_CYCLE       7'h14
`define RECOVER_NS      (34 * `CLK_NS + 10)
`define RECOVER_CYCLES  ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)

// ---------------------------------------------------------------------------
// slot count and parameter memory layout
// ---------------------------------------------------------------------------
`define MIN_SLOTS       6'h10
`define MAX_SLOTS       6'h20
`define BASE_SLOTS      6'h12
`define RST_SLOTS       6'h12
`define PRAM_DEPTH      512
`define PRAM_AW         9
`define BLOCK_WORDS     16
`define ALG_WORD        4'hF
`define REFRESH_ALG     4'hF
`define SILENT_ALG      4'h0

// ---------------------------------------------------------------------------
// datapath and serial output
// ---------------------------------------------------------------------------
`define DATA_W          19
`define ACC_W           24
`define OUT_W           20
`define GAIN_SHIFT      7
`define BIT_DIV         5'h10
`define BIT_HALF        5'h08
`define FRAME_BITS      6'h28

`endif

// *** synth_seq_pkg.sv ***
/*
  Types shared by the sequencer and its parameter memory.
  Assumes synth_seq_cfg.svh is on the include path.
*/
`include "synth_seq_cfg.svh"

package synth_seq_pkg;
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`ACC_W-1:0]  acc_t;

  // one host write into parameter memory
  typedef struct packed {
    logic                 wr;
    logic [`PRAM_AW-1:0]  addr;
    word_t                data;
  } host_wr_t;

  // four accumulator channels, two stereo pairs
  typedef acc_t [3:0] acc4_t;
endpackage

// *** param_ram.sv ***
/*
  512 x 19 parameter memory with one port shared by the sequencer and the
  host. Assumes host writes come from logic on mclk_i and that the host
  keeps its recovery time after each write.
*/
`timescale 1ns/1ps
`include "synth_seq_cfg.svh"

module param_ram
  import synth_seq_pkg::*;
(
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  // sequencer read port
  input  wire logic                rd_en_i,
  input  wire logic [`PRAM_AW-1:0] rd_addr_i,
  output logic      [`DATA_W-1:0]  rd_data_o,
  // host write port
  input  wire host_wr_t            host_i,
  output logic                     busy_o
);
  typedef struct packed {
    host_wr_t pend;
    word_t    rdata;
  } ram_state_t;

  word_t      mem [`PRAM_DEPTH];
  ram_state_t s_q;
  ram_state_t s_d;
  logic       commit;

  // the sequencer owns the port while it reads; a whole word is written in
  // one cycle so a reader never sees half an update
  assign commit = s_q.pend.wr && !rd_en_i;

  always_comb begin
    s_d = s_q;
    if (rd_en_i) begin
      s_d.rdata = mem[rd_addr_i];
    end
    if (commit) begin
      s_d.pend.wr = 1'b0;
    end
    // a new write while one waits is dropped; host recovery prevents it.
    // a write in the very cycle the old word commits is taken: set wins
    if (host_i.wr && (!s_q.pend.wr || commit)) begin
      s_d.pend = host_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (commit) begin
      mem[s_q.pend.addr] <= s_q.pend.data;
    end
  end

  assign rd_data_o = s_q.rdata;
  assign busy_o    = s_q.pend.wr;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_no_write_during_read;
    rd_en_i && s_q.pend.wr |=> s_q.pend.wr;
  endproperty
  a_no_write_during_read: assert property (p_no_write_during_read)
    else $error("pending write committed during a sequencer read");
endmodule

// *** synth_frame_seq.sv ***
/*
  Frame and slot sequencer: runs one algorithm per 68-cycle slot, mixes the
  slot output into four accumulators and shifts both stereo pairs per frame
  out on two serial lines. Assumes the host and config inputs are driven
  by logic on mclk_i.
*/
`timescale 1ns/1ps
`include "synth_seq_cfg.svh"

module synth_frame_seq
  import synth_seq_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // configuration
  input  wire logic        run_i,
  input  wire logic [3:0]  slot_sel_i,
  // host parameter writes
  input  wire host_wr_t    host_i,
  output logic             host_busy_o,
  // serial audio to converters
  output logic             serial_audio_out_o,
  output logic             serial_audio_out2_o,
  output logic             bit_clk_o,
  output logic             word_sel_o,
  // status
  output logic [4:0]       slot_o,
  output logic             frame_o,
  output logic             refresh_o
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0]       cyc;
    logic [4:0]       slot;
    logic [5:0]       nslots;
    logic             run;
    logic [3:0]       alg;
    word_t            level;
    logic [3:0][7:0]  gain;
    acc4_t            acc;
    logic [39:0]      sh_a;
    logic [39:0]      sh_b;
    logic [5:0]       bitn;
    logic [4:0]       bdiv;
    logic             sda;
    logic             sdb;
    logic             bclk;
    logic             ws;
    logic             frame;
    logic             refresh;
    logic             busy;
  } seq_state_t;

  localparam seq_state_t RST_STATE = '{nslots: `RST_SLOTS, bitn: `FRAME_BITS,
                                       default: '0};

  seq_state_t s_q;
  seq_state_t s_d;

  logic                 rd_en;
  logic [`PRAM_AW-1:0]  rd_addr;
  word_t                rd_data;
  logic                 ram_busy;
  logic [3:0]           word_idx;
  logic                 last_slot;
  logic [5:0]           sel_slots;
  logic signed [`DATA_W-1:0] sample;

  // ---------------------------------------------------------------------------
  // parameter memory
  // ---------------------------------------------------------------------------
  // block index equals slot number; words are fetched in cycles 0..15
  assign word_idx = s_q.cyc[3:0];
  assign rd_en    = (s_q.cyc < 7'(`BLOCK_WORDS));
  assign rd_addr  = {s_q.slot, word_idx};

  // the host may only write again after its recovery time, by which point
  // the pending word has always found a free cycle
  param_ram u_ram (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .rd_en_i   (rd_en),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data),
    .host_i    (host_i),
    .busy_o    (ram_busy)
  );

  // ---------------------------------------------------------------------------
  // slot count decode and stand-in voice
  // ---------------------------------------------------------------------------
  // top bit forces 16 slots, else 18 + 2*n, so the count is always even
  always_comb begin
    if (slot_sel_i[3]) begin
      sel_slots = `MIN_SLOTS;
    end else begin
      sel_slots = `BASE_SLOTS + {2'h0, slot_sel_i[2:0], 1'b0};
    end
  end

  assign last_slot = ({1'b0, s_q.slot} == s_q.nslots - 6'h01);

  // one algorithm per slot; the real algorithm cores sit outside this block,
  // so a level word shaped by the algorithm number stands in for them
  always_comb begin
    case (s_q.alg)
      `SILENT_ALG:  sample = '0;
      `REFRESH_ALG: sample = '0;
      default:      sample = $signed(s_q.level) >>> s_q.alg[1:0];
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic signed [`DATA_W+8:0] prod;
    logic signed [`ACC_W:0]    sum;
    prod = '0;
    sum  = '0;
    s_d  = s_q;
    s_d.frame   = 1'b0;
    s_d.refresh = 1'b0;
    s_d.busy    = ram_busy;

    // slot timing
    if (s_q.cyc == `SLOT_LAST) begin
      s_d.cyc = '0;
      if (last_slot) begin
        s_d.slot   = '0;
        s_d.nslots = sel_slots; // count changes only on a frame boundary
        s_d.run    = run_i;
      end else begin
        s_d.slot = s_q.slot + 5'h01;
      end
    end else begin
      s_d.cyc = s_q.cyc + 7'h01;
    end

    // capture parameter words one cycle after each read
    case (s_q.cyc)
      7'h01: s_d.level   = rd_data;
      7'h02: s_d.gain[0] = rd_data[7:0];
      7'h03: s_d.gain[1] = rd_data[7:0];
      7'h04: s_d.gain[2] = rd_data[7:0];
      7'h05: s_d.gain[3] = rd_data[7:0];
      7'h10: s_d.alg     = rd_data[3:0];
      default: ;
    endcase

    // mix: scale by per-channel gain and add with saturation; while idle
    // nothing is added and no refresh runs
    if (s_q.cyc == `MIX_CYCLE && s_q.run) begin
      s_d.refresh = (s_q.alg == `REFRESH_ALG);
      for (int ch = 0; ch < 4; ch++) begin
        prod = sample * $signed({1'b0, s_q.gain[ch]});
        sum  = $signed({s_q.acc[ch][`ACC_W-1], s_q.acc[ch]})
             + (`ACC_W+1)'(prod >>> `GAIN_SHIFT);
        if (sum[`ACC_W] != sum[`ACC_W-1]) begin
          s_d.acc[ch] = sum[`ACC_W] ? {1'b1, {(`ACC_W-1){1'b0}}}
                                    : {1'b0, {(`ACC_W-1){1'b1}}};
        end else begin
          s_d.acc[ch] = sum[`ACC_W-1:0];
        end
      end
    end

    // serial shifter: one bit every BIT_DIV clocks, msb first, left then right
    if (s_q.bitn < `FRAME_BITS) begin
      s_d.bdiv = s_q.bdiv + 5'h01;
      s_d.bclk = (s_q.bdiv == `BIT_HALF - 5'h01) ? 1'b1 : s_q.bclk;
      if (s_q.bdiv == `BIT_DIV - 5'h01) begin
        s_d.bdiv = '0;
        s_d.bclk = 1'b0;
        s_d.bitn = s_q.bitn + 6'h01;
        s_d.sh_a = {s_q.sh_a[38:0], 1'b0};
        s_d.sh_b = {s_q.sh_b[38:0], 1'b0};
        s_d.sda  = s_q.sh_a[38];
        s_d.sdb  = s_q.sh_b[38];
        s_d.ws   = (s_q.bitn + 6'h01 >= 6'(`OUT_W));
      end
    end else begin
      s_d.bclk = 1'b0;
    end

    // frame end: move accumulators to the shifters and clear them
    if (s_q.cyc == `SLOT_LAST && last_slot) begin
      s_d.frame = 1'b1;
      s_d.sh_a  = {s_q.acc[0][`ACC_W-1 -: `OUT_W], s_q.acc[1][`ACC_W-1 -: `OUT_W]};
      s_d.sh_b  = {s_q.acc[2][`ACC_W-1 -: `OUT_W], s_q.acc[3][`ACC_W-1 -: `OUT_W]};
      s_d.sda   = s_q.acc[0][`ACC_W-1];
      s_d.sdb   = s_q.acc[2][`ACC_W-1];
      s_d.ws    = 1'b0;
      s_d.bitn  = '0;
      s_d.bdiv  = '0;
      s_d.bclk  = 1'b0;
      s_d.acc   = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  // run starts clear, so all slots are idle until software enables them
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from state flip-flops
  assign serial_audio_out_o  = s_q.sda;
  assign serial_audio_out2_o = s_q.sdb;
  assign bit_clk_o           = s_q.bclk;
  assign word_sel_o          = s_q.ws;
  assign slot_o              = s_q.slot;
  assign frame_o             = s_q.frame;
  assign refresh_o           = s_q.refresh;
  assign host_busy_o         = s_q.busy;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_slot_len;
    s_q.cyc == 7'h00 |-> ##67 (s_q.cyc == `SLOT_LAST) ##1 (s_q.cyc == 7'h00);
  endproperty
  a_slot_len: assert property (p_slot_len)
    else $error("slot did not last 68 clocks");

  property p_slot_wrap;
    s_q.cyc == `SLOT_LAST && last_slot |=> s_q.slot == 5'h00 && s_q.frame;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap)
    else $error("slot counter failed to wrap with a frame pulse");

  property p_slot_step;
    s_q.cyc == `SLOT_LAST && !last_slot |=> s_q.slot == $past(s_q.slot) + 5'h01;
  endproperty
  a_slot_step: assert property (p_slot_step)
    else $error("slot counter did not advance");

  property p_count_even;
    !s_q.nslots[0] && s_q.nslots >= `MIN_SLOTS && s_q.nslots <= `MAX_SLOTS;
  endproperty
  a_count_even: assert property (p_count_even)
    else $error("slot count out of range or odd");

  property p_block_addr;
    rd_en |-> rd_addr[8:4] == s_q.slot && rd_addr[3:0] == s_q.cyc[3:0];
  endproperty
  a_block_addr: assert property (p_block_addr)
    else $error("parameter read outside the slot's block");

  property p_idle_hold;
    !s_q.run && s_q.cyc == `MIX_CYCLE |=> $stable(s_q.acc) && !s_q.refresh;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle slot changed accumulators");

  property p_refresh_alg;
    s_q.refresh |-> s_q.alg == `REFRESH_ALG && s_q.run;
  endproperty
  a_refresh_alg: assert property (p_refresh_alg)
    else $error("refresh without the refresh algorithm");

  property p_frame_clear;
    s_q.frame |-> s_q.acc == '0 && s_q.bitn == 6'h00 && !s_q.ws;
  endproperty
  a_frame_clear: assert property (p_frame_clear)
    else $error("accumulators not cleared at frame end");

  property p_frame_out;
    s_q.frame |-> ##[600:660] s_q.bitn == `FRAME_BITS;
  endproperty
  a_frame_out: assert property (p_frame_out)
    else $error("frame sample not shifted out in time");
endmodule

// *** host_model.sv ***
/*
  Behavioural host that loads parameter words into the sequencer.
  Assumes it shares mclk_i with the sequencer it feeds.
*/
`timescale 1ns/1ps
`include "synth_seq_cfg.svh"

module host_model
  import synth_seq_pkg::*;
(
  // clock
  input  wire logic mclk_i,
  // write port toward the sequencer
  output host_wr_t  host_o
);
  // ---------------------------------------------------------------------
  // write task
  // ---------------------------------------------------------------------
  initial host_o = '0;

  // one-cycle strobe; the released bus shows inverted values so a stale
  // word never passes for a live one, then the recovery gap is kept
  task automatic put(input logic [`PRAM_AW-1:0] addr, input word_t data);
    @(posedge mclk_i);
    host_o <= '{wr: 1'b1, addr: addr, data: data};
    @(posedge mclk_i);
    host_o <= '{wr: 1'b0, addr: ~addr, data: ~data};
    repeat (`RECOVER_CYCLES - 1) @(posedge mclk_i);
  endtask
endmodule

// *** synth_frame_seq_tb_top.sv ***
/*
  Self-checking bench for the frame and slot sequencer: reset state, slot
  and frame timing for every slot count code, host write arbitration,
  mixing, refresh and serial output.
  Assumes the design files and host_model.sv are compiled first.
*/
`timescale 1ns/1ps
`include "synth_seq_cfg.svh"

module synth_frame_seq_tb_top
  import synth_seq_pkg::*;
();
  // -----------------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------------
  logic       mclk_i;
  logic       reset_i;
  logic       run_i;
  logic [3:0] slot_sel_i;
  host_wr_t   host_i;
  logic       host_busy_o;
  logic       serial_audio_out_o;
  logic       serial_audio_out2_o;
  logic       bit_clk_o;
  logic       word_sel_o;
  logic [4:0] slot_o;
  logic       frame_o;
  logic       refresh_o;
  int         n_mismatch;
  int         samples_checked;

  synth_frame_seq i_synth_frame_seq (
    .mclk_i(mclk_i), .reset_i(reset_i), .run_i(run_i), .slot_sel_i(slot_sel_i),
    .host_i(host_i), .host_busy_o(host_busy_o),
    .serial_audio_out_o(serial_audio_out_o), .serial_audio_out2_o(serial_audio_out2_o),
    .bit_clk_o(bit_clk_o), .word_sel_o(word_sel_o), .slot_o(slot_o),
    .frame_o(frame_o), .refresh_o(refresh_o)
  );

  host_model i_host_model (
    .mclk_i(mclk_i),
    .host_o(host_i)
  );

  // 40 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // -----------------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------------
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for the frame pulse; longest frame is 2176 cycles
  task automatic wait_frame();
    int i;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (frame_o !== 1'b1 && i < 3000);
    check("frame pulse", 40'(i < 3000), 40'h1);
  endtask

  task automatic count_refresh(output int k);
    int i;
    k = 0;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
      if (refresh_o === 1'b1) begin
        k++;
      end
    end while (frame_o !== 1'b1 && i < 3000);
    check("refresh window", 40'(i < 3000), 40'h1);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] idle;
    repeat (2) @(posedge mclk_i);
    idle = {slot_o, frame_o, host_busy_o, serial_audio_out_o, serial_audio_out2_o, bit_clk_o,
            word_sel_o, refresh_o};
    check("idle outputs", 40'(idle), 40'h0);
  endtask

  // busy must rise two cycles after the strobe is taken and clear soon after
  task automatic t_busy();
    int k;
    fork
      i_host_model.put(9'h1F0, 19'h00000);
      begin
        do @(posedge mclk_i); while (host_i.wr !== 1'b1);
        k = 0;
        do begin
          @(posedge mclk_i);
          k++;
        end while (host_busy_o !== 1'b1 && k < 30);
        check("busy rise", 40'(k), 40'h2);
        k = 0;
        do begin
          @(posedge mclk_i);
          k++;
        end while (host_busy_o !== 1'b0 && k < 30);
        check("busy clear", 40'(k < 24), 40'h1);
      end
    join
  endtask

  // two frames let the new code latch; the third is measured slot by slot
  task automatic t_slots(input logic [3:0] code);
    int         n;
    int         cyc;
    int         run;
    logic [4:0] prev;
    n = code[3] ? 16 : 18 + 2 * int'(code[2:0]);
    slot_sel_i <= code;
    wait_frame();
    wait_frame();
    prev = slot_o;
    cyc = 0;
    run = 0;
    do begin
      @(posedge mclk_i);
      cyc++;
      run++;
      if (slot_o !== prev) begin
        check("slot length", 40'(run), 40'd68);
        check("slot step", 40'(slot_o), 40'((prev + 1) % n));
        prev = slot_o;
        run = 0;
      end
    end while (frame_o !== 1'b1 && cyc < 3000);
    check("frame length", 40'(cyc), 40'(68 * n));
  endtask

  // silence all blocks, then slot 0 alg 1, slot 1 refresh, slot 2 alg 2
  task automatic t_audio();
    int         k;
    logic [39:0] a;
    logic [39:0] b;
    logic [39:0] ws;
    for (int s = 0; s < 32; s++) begin
      for (int w = 0; w < 5; w++) begin
        i_host_model.put(9'(s * 16 + w), '0);
      end
      i_host_model.put(9'(s * 16 + 15), '0);
    end
    i_host_model.put(9'h000, 19'h10000);
    i_host_model.put(9'h001, 19'h00080);
    i_host_model.put(9'h002, 19'h00040);
    i_host_model.put(9'h003, 19'h00020);
    i_host_model.put(9'h00F, 19'h00001);
    i_host_model.put(9'h01F, 19'h0000F);
    i_host_model.put(9'h020, 19'h10000);
    i_host_model.put(9'h024, 19'h00080);
    i_host_model.put(9'h02F, 19'h00002);
    wait_frame();
    count_refresh(k);
    check("refresh while stopped", 40'(k), 40'h0);
    run_i <= 1'b1;
    slot_sel_i <= 4'h8;
    wait_frame();
    wait_frame();
    count_refresh(k);
    check("refresh per frame", 40'(k), 40'h1);
    for (int i = 0; i < 40; i++) begin
      @(posedge bit_clk_o);
      a = {a[38:0], serial_audio_out_o};
      b = {b[38:0], serial_audio_out2_o};
      ws = {ws[38:0], word_sel_o};
    end
    check("first pair", a, {20'h00800, 20'h00400});
    check("second pair", b, {20'h00200, 20'h00400});
    check("word select", ws, {20'h00000, 20'hFFFFF});
  endtask

  // -----------------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    run_i = 1'b0;
    slot_sel_i = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_busy();
    for (int c = 0; c < 16; c++) begin
      t_slots(4'(c));
    end
    t_audio();
    close_out();
  end

  // covers the full code sweep plus loading, with margin
  initial begin
    repeat (95000) @(posedge mclk_i);
    n_mismatch++;
    close_out();
  end
endmodule
